// *** common/cra_regs.svh ***
`ifndef CRA_REGS_SVH
`define CRA_REGS_SVH
// control token values
`define CRA_TOK_END 8'h01
`define CRA_TOK_ACK 8'h03
`define CRA_TOK_NAK 8'h04
`define CRA_TOK_PWR 8'h24
`define CRA_TOK_PRD 8'h25
`define CRA_TOK_CWR 8'hc0
`define CRA_TOK_CRD 8'hc1
// destination low fields
`define CRA_DST_TILE 16'hc20c
`define CRA_DST_NODE 16'hc30c
`define CRA_DST_PERI 8'h02
// reply id low byte that suppresses a write reply
`define CRA_NO_REPLY 8'hff
// body lengths in bytes after the opening token
`define CRA_LEN_CWR 4'd9
`define CRA_LEN_CRD 4'd5
`define CRA_LEN_PHDR 4'd5
`define CRA_MAX_BODY 4'd9
`define CRA_MAX_PSIZE 8'h04
`endif

// *** common/cra_pkg.sv ***
package cra_pkg;
    typedef enum logic [1:0] {
        CRA_SP_TILE = 2'h0,
        CRA_SP_NODE = 2'h1,
        CRA_SP_PERI = 2'h2,
        CRA_SP_NONE = 2'h3
    } cra_space_e;
    typedef logic [7:0] cra_byte_t;
endpackage

// *** common/cra_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
// token link: one token per valid&ready, ctrl marks a control token
interface cra_link_if;
    logic req_valid;
    logic req_ready;
    logic req_ctrl;
    logic [7:0] req_byte;
    logic [31:0] req_dest;
    logic rsp_valid;
    logic rsp_ready;
    logic rsp_ctrl;
    logic [7:0] rsp_byte;
    logic [23:0] rsp_dest;
    modport dev (
        input req_valid, req_ctrl, req_byte, req_dest, rsp_ready,
        output req_ready, rsp_valid, rsp_ctrl, rsp_byte, rsp_dest
    );
    modport host (
        output req_valid, req_ctrl, req_byte, req_dest, rsp_ready,
        input req_ready, rsp_valid, rsp_ctrl, rsp_byte, rsp_dest
    );
endinterface
`default_nettype wire

// *** verilog/cra_device.sv ***
// Behaviour
// - requests carry 24-bit reply channel id
// - reply id low byte ff suppresses write reply
// - multi-byte fields travel msb first
// - tile port answers destination nnnn c20c
// - config write: 192, id, reg16, data32, 1
// - config read: 193, id, reg16, 1
// - write answered 3,1 or 4,1
// - config read answered 3, word, 1
// - node port answers nnnn c30c, same formats
// - peripheral port answers nnnn pp 02
// - periph write: 36, id, reg, size, bytes, 1
// - periph read: 37, id, reg, size, 1
// - periph read answered 3, bytes, 1
`timescale 1ns/100ps
`default_nettype none
`include "cra_regs.svh"
module cra_device import cra_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    cra_link_if.dev link,
    input wire logic [15:0] i_tile_id,
    input wire logic [15:0] i_node_id,
    output logic o_acc_valid,
    output logic o_acc_write,
    output logic [1:0] o_acc_space,
    output logic [7:0] o_acc_periph,
    output logic [15:0] o_acc_reg,
    output logic [7:0] o_acc_size,
    output logic [31:0] o_acc_wdata,
    input wire logic i_acc_done,
    input wire logic i_acc_ok,
    input wire logic [31:0] i_acc_rdata
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_BODY = 4'b0010,
        S_ACC = 4'b0100,
        S_REPLY = 4'b1000
    } cra_dstate_e;

    function automatic cra_space_e dest_space(input logic [31:0] d,
                                             input logic [15:0] tid,
                                             input logic [15:0] nid);
        if (d[31:16] == tid && d[15:0] == `CRA_DST_TILE) begin
            return CRA_SP_TILE;
        end else if (d[31:16] == nid && d[15:0] == `CRA_DST_NODE) begin
            return CRA_SP_NODE;
        end else if (d[31:16] == nid && d[7:0] == `CRA_DST_PERI) begin
            return CRA_SP_PERI;
        end
        return CRA_SP_NONE;
    endfunction

    cra_dstate_e state;
    cra_space_e space;
    cra_byte_t op;
    cra_byte_t msg [0:8];
    logic [3:0] cnt;
    logic ovf;
    logic [7:0] periph;
    logic [31:0] rdata;
    logic [7:0] rem;
    logic tail;
    logic take;
    logic fmt_ok;
    logic is_write;
    logic [23:0] reply_id;
    logic [7:0] psize;
    logic [31:0] next_wdata;
    logic rsp_fire;

    assign link.req_ready = (state == S_IDLE) || (state == S_BODY);
    assign take = link.req_valid && link.req_ready;
    assign rsp_fire = link.rsp_valid && link.rsp_ready;
    // reply destination from first three body bytes
    assign reply_id = {msg[0], msg[1], msg[2]};
    assign psize = msg[4];
    assign is_write = (op == `CRA_TOK_CWR) || (op == `CRA_TOK_PWR);

    always_comb begin
        fmt_ok = 1'b0;
        if (!ovf) begin
            unique case (op)
                `CRA_TOK_CWR: fmt_ok = space != CRA_SP_PERI && space != CRA_SP_NONE
                                       && cnt == `CRA_LEN_CWR;
                `CRA_TOK_CRD: fmt_ok = space != CRA_SP_PERI && space != CRA_SP_NONE
                                       && cnt == `CRA_LEN_CRD;
                `CRA_TOK_PWR: fmt_ok = space == CRA_SP_PERI && psize != 8'h00
                                       && psize <= `CRA_MAX_PSIZE
                                       && cnt == `CRA_LEN_PHDR + psize[3:0];
                `CRA_TOK_PRD: fmt_ok = space == CRA_SP_PERI && psize != 8'h00
                                       && psize <= `CRA_MAX_PSIZE
                                       && cnt == `CRA_LEN_PHDR;
                default: fmt_ok = 1'b0;
            endcase
        end
    end

    always_comb begin
        next_wdata = 32'h0;
        if (op == `CRA_TOK_CWR) begin
            next_wdata = {msg[5], msg[6], msg[7], msg[8]};
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (k < int'(psize)) begin
                    next_wdata = {next_wdata[23:0], msg[5 + k]};
                end
            end
        end
    end

    // receive side; ovf keeps a too long message from overrunning msg
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            cnt <= 4'h0;
            ovf <= 1'b0;
            op <= 8'h00;
            space <= CRA_SP_NONE;
            periph <= 8'h00;
            for (int i = 0; i < 9; i++) begin
                msg[i] <= 8'h00;
            end
        end else if (take && state == S_IDLE && link.req_ctrl) begin
            op <= link.req_byte;
            space <= dest_space(link.req_dest, i_tile_id, i_node_id);
            periph <= link.req_dest[15:8];
            cnt <= 4'h0;
            ovf <= 1'b0;
        end else if (take && state == S_BODY && !link.req_ctrl) begin
            if (cnt == `CRA_MAX_BODY) begin
                ovf <= 1'b1;
            end else begin
                msg[cnt] <= link.req_byte;
                cnt <= cnt + 4'd1;
            end
        // a stray control token spoils the message
        end else if (take && state == S_BODY && link.req_byte != `CRA_TOK_END) begin
            ovf <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= S_IDLE;
        end else begin
            unique case (state)
                S_IDLE: begin
                    if (take && link.req_ctrl) begin
                        state <= S_BODY;
                    end
                end
                // any control token ends the body; only a good end token leads to the access
                S_BODY: begin
                    if (take && link.req_ctrl) begin
                        state <= (fmt_ok && !ovf && link.req_byte == `CRA_TOK_END)
                                 ? S_ACC : S_REPLY;
                    end
                end
                S_ACC: begin
                    if (i_acc_done) begin
                        state <= (is_write && reply_id[7:0] == `CRA_NO_REPLY)
                                 ? S_IDLE : S_REPLY;
                    end
                end
                S_REPLY: begin
                    if (rsp_fire && tail) begin
                        state <= S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_acc_write <= 1'b0;
            o_acc_space <= 2'h0;
            o_acc_periph <= 8'h00;
            o_acc_reg <= 16'h0;
            o_acc_size <= 8'h00;
            o_acc_wdata <= 32'h0;
        end else if (state == S_BODY && take && link.req_ctrl) begin
            o_acc_write <= is_write;
            o_acc_space <= space;
            o_acc_periph <= periph;
            o_acc_reg <= (space == CRA_SP_PERI) ? {8'h00, msg[3]} : {msg[3], msg[4]};
            o_acc_size <= (space == CRA_SP_PERI) ? psize : 8'h04;
            o_acc_wdata <= next_wdata;
        end
    end

    assign o_acc_valid = (state == S_ACC);

    // reply tokens are registered; rem counts data bytes still to go
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            link.rsp_valid <= 1'b0;
            link.rsp_ctrl <= 1'b0;
            link.rsp_byte <= 8'h00;
            link.rsp_dest <= 24'h0;
            rdata <= 32'h0;
            rem <= 8'h00;
            tail <= 1'b0;
        end else if (state == S_BODY && take && link.req_ctrl
                     && !(fmt_ok && !ovf && link.req_byte == `CRA_TOK_END)) begin
            // malformed request gets the failure reply
            link.rsp_valid <= 1'b1;
            link.rsp_ctrl <= 1'b1;
            link.rsp_byte <= `CRA_TOK_NAK;
            link.rsp_dest <= reply_id;
            rem <= 8'h00;
            tail <= 1'b0;
        end else if (state == S_ACC && i_acc_done) begin
            link.rsp_valid <= !(is_write && reply_id[7:0] == `CRA_NO_REPLY);
            link.rsp_ctrl <= 1'b1;
            link.rsp_byte <= i_acc_ok ? `CRA_TOK_ACK : `CRA_TOK_NAK;
            link.rsp_dest <= reply_id;
            rdata <= i_acc_rdata;
            // a good read returns the word
            // a good periph read returns size bytes
            rem <= (i_acc_ok && !is_write) ? o_acc_size : 8'h00;
            tail <= 1'b0;
        end else if (rsp_fire) begin
            if (tail) begin
                link.rsp_valid <= 1'b0;
            end else if (rem != 8'h00) begin
                link.rsp_ctrl <= 1'b0;
                link.rsp_byte <= 8'(rdata >> (8 * (rem - 8'd1)));
                rem <= rem - 8'd1;
            end else begin
                link.rsp_ctrl <= 1'b1;
                link.rsp_byte <= `CRA_TOK_END;
                tail <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/cra_host.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "cra_regs.svh"
module cra_host import cra_pkg::*; (
    input wire logic i_clk,
    input wire logic i_rst_n,
    cra_link_if.host link,
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic i_cmd_write,
    input wire logic i_cmd_periph,
    input wire logic [31:0] i_cmd_dest,
    input wire logic [23:0] i_cmd_reply_id,
    input wire logic [15:0] i_cmd_reg,
    input wire logic [7:0] i_cmd_size,
    input wire logic [31:0] i_cmd_data,
    output logic o_rsp_valid,
    output logic o_rsp_ok,
    output logic [31:0] o_rsp_data
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_SEND = 3'b010,
        H_WAIT = 3'b100
    } cra_hstate_e;

    cra_hstate_e state;
    logic wr;
    logic per;
    logic [23:0] rid;
    logic [15:0] rnum;
    logic [7:0] size;
    logic [31:0] data;
    logic [4:0] step;
    logic [4:0] last;
    logic [8:0] tok;
    logic [8:0] nxt;
    logic send_fire;
    logic rsp_fire;

    // token at a step of the message, {ctrl, byte}
    function automatic logic [8:0] host_token(input logic [4:0] s, input logic w,
                                             input logic p, input logic [23:0] id,
                                             input logic [15:0] r, input logic [7:0] n,
                                             input logic [31:0] d, input logic [4:0] l);
        logic [4:0] k;
        k = s - 5'd6;
        // config write opener / config read opener
        // periph write opener / periph read opener
        if (s == 5'd0) begin
            return {1'b1, p ? (w ? `CRA_TOK_PWR : `CRA_TOK_PRD)
                            : (w ? `CRA_TOK_CWR : `CRA_TOK_CRD)};
        end else if (s == l) begin
            return {1'b1, `CRA_TOK_END};
        end else if (s <= 5'd3) begin
            return {1'b0, 8'(id >> (8 * (3 - int'(s))))};
        end else if (p) begin
            if (s == 5'd4) begin
                return {1'b0, r[7:0]};
            end else if (s == 5'd5) begin
                return {1'b0, n};
            end
            return {1'b0, 8'(d >> (8 * (int'(n) - 1 - int'(k))))};
        end else if (s <= 5'd5) begin
            return {1'b0, s == 5'd4 ? r[15:8] : r[7:0]};
        end
        return {1'b0, 8'(d >> (8 * (3 - int'(k))))};
    endfunction

    assign tok = host_token(step, wr, per, rid, rnum, size, data, last);
    // token after the one on the link, loaded as the current one is taken
    assign nxt = host_token(step + 5'd1, wr, per, rid, rnum, size, data, last);
    assign o_cmd_ready = (state == H_IDLE);
    assign send_fire = link.req_valid && link.req_ready;
    assign rsp_fire = link.rsp_valid && link.rsp_ready;
    assign link.rsp_ready = (state == H_WAIT);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr <= 1'b0;
            per <= 1'b0;
            rid <= 24'h0;
            rnum <= 16'h0;
            size <= 8'h00;
            data <= 32'h0;
            last <= 5'd0;
            link.req_dest <= 32'h0;
        end else if (i_cmd_valid && o_cmd_ready) begin
            wr <= i_cmd_write;
            per <= i_cmd_periph;
            rid <= i_cmd_reply_id;
            rnum <= i_cmd_reg;
            size <= i_cmd_size;
            data <= i_cmd_data;
            link.req_dest <= i_cmd_dest;
            if (i_cmd_periph) begin
                last <= i_cmd_write ? 5'd6 + i_cmd_size[4:0] : 5'd6;
            end else begin
                last <= i_cmd_write ? 5'd10 : 5'd6;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= H_IDLE;
            step <= 5'd0;
        end else begin
            unique case (state)
                H_IDLE: begin
                    if (i_cmd_valid) begin
                        state <= H_SEND;
                        step <= 5'd0;
                    end
                end
                H_SEND: begin
                    if (send_fire) begin
                        step <= step + 5'd1;
                        if (step == last) begin
                            // no reply expected on suppressed write
                            state <= (wr && rid[7:0] == `CRA_NO_REPLY) ? H_IDLE : H_WAIT;
                        end
                    end
                end
                H_WAIT: begin
                    if (rsp_fire && link.rsp_ctrl && link.rsp_byte == `CRA_TOK_END) begin
                        state <= H_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            link.req_valid <= 1'b0;
            link.req_ctrl <= 1'b0;
            link.req_byte <= 8'h00;
        end else if (state == H_SEND && !(send_fire && step == last)) begin
            link.req_valid <= 1'b1;
            link.req_ctrl <= send_fire ? nxt[8] : tok[8];
            link.req_byte <= send_fire ? nxt[7:0] : tok[7:0];
        end else begin
            link.req_valid <= 1'b0;
        end
    end

    // head token decides success / word follows
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_rsp_valid <= 1'b0;
            o_rsp_ok <= 1'b0;
            o_rsp_data <= 32'h0;
        end else begin
            o_rsp_valid <= 1'b0;
            if (state == H_SEND && send_fire && step == last
                && wr && rid[7:0] == `CRA_NO_REPLY) begin
                o_rsp_valid <= 1'b1;
                o_rsp_ok <= 1'b1;
            end else if (rsp_fire && link.rsp_ctrl) begin
                if (link.rsp_byte == `CRA_TOK_END) begin
                    o_rsp_valid <= 1'b1;
                end else begin
                    o_rsp_ok <= (link.rsp_byte == `CRA_TOK_ACK);
                    o_rsp_data <= 32'h0;
                end
            // periph bytes shift in, msb first
            end else if (rsp_fire) begin
                o_rsp_data <= {o_rsp_data[23:0], link.rsp_byte};
            end
        end
    end
endmodule
`default_nettype wire

// *** test/cra_link_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module cra_link_monitor (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_ctrl,
    input wire logic [7:0] req_byte,
    input wire logic [31:0] req_dest,
    input wire logic rsp_valid,
    input wire logic rsp_ready,
    input wire logic rsp_ctrl,
    input wire logic [7:0] rsp_byte,
    input wire logic [23:0] rsp_dest
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic rq, rs, r_end, s_end, wr, ack;
    logic [7:0] op;
    logic [1:0] idx;
    logic [23:0] id;
    logic [2:0] dcnt;
    assign rq = req_valid && req_ready;
    assign rs = rsp_valid && rsp_ready;
    assign r_end = rq && req_ctrl && req_byte == 8'h01;
    assign s_end = rs && rsp_ctrl && rsp_byte == 8'h01;
    assign wr = op == 8'hc0 || op == 8'h24;
    // only the first three body bytes form the reply id
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            op <= 8'h00;
            idx <= 2'h0;
            id <= 24'h0;
        end else if (rq && req_ctrl && req_byte != 8'h01) begin
            op <= req_byte;
            idx <= 2'h0;
        end else if (rq && !req_ctrl && idx != 2'h3) begin
            id <= {id[15:0], req_byte};
            idx <= idx + 2'h1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || s_end) begin
            ack <= 1'b0;
            dcnt <= 3'h0;
        end else if (rs && rsp_ctrl && rsp_byte == 8'h03) begin
            ack <= 1'b1;
        end else if (rs && !rsp_ctrl) begin
            dcnt <= dcnt + 3'h1;
        end
    end
    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable({rsp_ctrl, rsp_byte, rsp_dest});
    endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("reply token changed while stalled");
    property p_req_hold;
        req_valid && !req_ready |=> req_valid && $stable({req_ctrl, req_byte, req_dest});
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request token changed while stalled");
    property p_head;
        $rose(rsp_valid) |-> rsp_ctrl && (rsp_byte == 8'h03 || rsp_byte == 8'h04);
    endproperty
    a_head: assert property (p_head) else $error("reply does not open with 3 or 4");
    property p_nak_end;
        rs && rsp_ctrl && rsp_byte == 8'h04 |-> ##[1:4] (rsp_valid && rsp_ctrl && rsp_byte == 8'h01);
    endproperty
    a_nak_end: assert property (p_nak_end) else $error("failure reply not closed by 1");
    property p_data_in_ack;
        rsp_valid && !rsp_ctrl |-> ack;
    endproperty
    a_data_in_ack: assert property (p_data_in_ack) else $error("reply data outside success");
    property p_rd_len;
        s_end && ack && op == 8'hc1 |-> dcnt == 3'h4;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("config read reply not four bytes");
    property p_wr_nodata;
        s_end && wr |-> dcnt == 3'h0;
    endproperty
    a_wr_nodata: assert property (p_wr_nodata) else $error("write reply carries data");
    property p_dest;
        rsp_valid |-> rsp_dest == id;
    endproperty
    a_dest: assert property (p_dest) else $error("reply sent to wrong channel");
    property p_quiet;
        r_end && wr && id[7:0] == 8'hff |=> !rsp_valid [*8];
    endproperty
    a_quiet: assert property (p_quiet) else $error("suppressed write was answered");
    property p_refuse;
        r_end |=> !req_ready;
    endproperty
    a_refuse: assert property (p_refuse) else $error("request taken during access");
endmodule
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "cra_regs.svh"
module tb;
    import cra_pkg::*;
    logic i_clk, i_rst_n, c_valid, c_ready, c_w, c_p, rsp_v, rsp_ok;
    logic acc_valid, acc_write, acc_ok, s_w;
    logic acc_done = 1'b0;
    logic [1:0] acc_space, s_sp;
    logic [7:0] c_n, acc_periph, acc_size, s_pp, s_n;
    logic [15:0] c_reg, acc_reg, s_reg, tile_id, node_id;
    logic [23:0] c_id;
    logic [31:0] c_dest, c_data, rsp_data, acc_wdata, acc_rdata, s_wd, d;
    logic [32:0] got;
    int error_cnt = 0;
    int samples_checked = 0;
    int acc_cnt = 0;
    int c0;
    cra_link_if link();
    cra_host u_cra_host (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link), .i_cmd_valid(c_valid),
        .o_cmd_ready(c_ready), .i_cmd_write(c_w), .i_cmd_periph(c_p), .i_cmd_dest(c_dest),
        .i_cmd_reply_id(c_id), .i_cmd_reg(c_reg), .i_cmd_size(c_n), .i_cmd_data(c_data),
        .o_rsp_valid(rsp_v), .o_rsp_ok(rsp_ok), .o_rsp_data(rsp_data));
    cra_device u_cra_device (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(link), .i_tile_id(tile_id),
        .i_node_id(node_id), .o_acc_valid(acc_valid), .o_acc_write(acc_write),
        .o_acc_space(acc_space), .o_acc_periph(acc_periph), .o_acc_reg(acc_reg),
        .o_acc_size(acc_size), .o_acc_wdata(acc_wdata), .i_acc_done(acc_done),
        .i_acc_ok(acc_ok), .i_acc_rdata(acc_rdata));
    cra_link_monitor u_cra_link_monitor (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .req_valid(link.req_valid), .req_ready(link.req_ready), .req_ctrl(link.req_ctrl),
        .req_byte(link.req_byte), .req_dest(link.req_dest), .rsp_valid(link.rsp_valid),
        .rsp_ready(link.rsp_ready), .rsp_ctrl(link.rsp_ctrl), .rsp_byte(link.rsp_byte),
        .rsp_dest(link.rsp_dest));
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // register file stand-in: answers each access once, one cycle later
    always @(negedge i_clk) begin
        acc_done <= acc_valid && !acc_done;
        if (acc_valid && !acc_done) begin
            acc_cnt <= acc_cnt + 1;
            {s_w, s_sp, s_pp, s_reg, s_n, s_wd} <= {acc_write, acc_space, acc_periph, acc_reg,
                acc_size, acc_wdata};
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [66:0] e, input logic [66:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    function automatic logic [31:0] msk(input logic [7:0] n);
        return (n >= 8'h04) ? 32'hffffffff : ((32'h1 << (8 * n)) - 32'h1);
    endfunction
    task automatic cmd(input logic w, input logic p, input logic [31:0] dst,
            input logic [23:0] id, input logic [15:0] r, input logic [7:0] n,
            input logic [31:0] x);
        int k;
        @(negedge i_clk);
        {c_w, c_p, c_dest, c_id, c_reg, c_n, c_data} = {w, p, dst, id, r, n, x};
        c_valid = 1'b1;
        for (k = 0; k < 50 && c_ready !== 1'b1; k++) @(negedge i_clk);
        if (c_ready !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
        @(negedge i_clk);
        c_valid = 1'b0;
        for (k = 0; k < 300 && rsp_v !== 1'b1; k++) @(negedge i_clk);
        if (rsp_v !== 1'b1) begin
            error_cnt++;
            print_verdict();
        end
        got = {rsp_ok, rsp_data};
    endtask
    task automatic t_config();
        acc_ok = 1'b1;
        acc_rdata = 32'h8badf00d;
        for (int i = 0; i < 2; i++) begin
            d = i ? {node_id, `CRA_DST_NODE} : {tile_id, `CRA_DST_TILE};
            cmd(1'b1, 1'b0, d, 24'h123456, 16'h1234, 8'h04, 32'hdeadbeef);
            check({1'b1, 2'(i), 16'h1234, 8'h04, 32'hdeadbeef}, {s_w, s_sp, s_reg, s_n, s_wd});
            check(67'h1, 67'(got[32]));
            cmd(1'b0, 1'b0, d, 24'h654321, 16'h00a5, 8'h04, 32'h0);
            check({1'b0, 2'(i), 16'h00a5, 8'h04}, {s_w, s_sp, s_reg, s_n});
            check({1'b1, 32'h8badf00d}, got);
        end
        $display("test config done");
    endtask
    task automatic t_fail();
        acc_ok = 1'b0;
        cmd(1'b1, 1'b0, {tile_id, `CRA_DST_TILE}, 24'h000102, 16'h0002, 8'h04, 32'h1);
        check(67'h0, 67'(got[32]));
        cmd(1'b0, 1'b0, {node_id, `CRA_DST_NODE}, 24'h000102, 16'h0003, 8'h04, 32'h0);
        check(67'h0, 67'(got[32]));
        $display("test fail done");
    endtask
    task automatic t_periph();
        acc_ok = 1'b1;
        acc_rdata = 32'h11223344;
        d = {node_id, 8'h5a, `CRA_DST_PERI};
        for (int n = 1; n <= 4; n++) begin
            cmd(1'b1, 1'b1, d, 24'h0a0b0c, 16'h0033, 8'(n), 32'hcafe1234);
            check({1'b1, 2'h2, 8'h5a, 8'h33, 8'(n)}, {s_w, s_sp, s_pp, s_reg[7:0], s_n});
            check(67'(32'hcafe1234 & msk(8'(n))), 67'(s_wd));
            check(67'h1, 67'(got[32]));
            cmd(1'b0, 1'b1, d, 24'h0a0b0d, 16'h0044, 8'(n), 32'h0);
            check({1'b0, 2'h2, 8'h5a, 8'h44, 8'(n)}, {s_w, s_sp, s_pp, s_reg[7:0], s_n});
            check({1'b1, 32'h11223344 & msk(8'(n))}, 67'(got));
        end
        $display("test periph done");
    endtask
    task automatic t_quiet();
        // the host reports a suppressed write as done once its last token leaves
        acc_ok = 1'b1;
        c0 = acc_cnt;
        cmd(1'b1, 1'b0, {tile_id, `CRA_DST_TILE}, 24'h1234ff, 16'h0010, 8'h04, 32'h55aa55aa);
        for (int k = 0; k < 40 && acc_cnt == c0; k++) @(negedge i_clk);
        check(67'(c0 + 1), 67'(acc_cnt));
        check({1'b1, 16'h0010, 32'h55aa55aa}, {s_w, s_reg, s_wd});
        $display("test quiet done");
    endtask
    task automatic t_reject();
        acc_ok = 1'b1;
        c0 = acc_cnt;
        cmd(1'b1, 1'b0, {~tile_id, `CRA_DST_TILE}, 24'h000203, 16'h0001, 8'h04, 32'h7);
        check(67'h0, 67'(got[32]));
        cmd(1'b0, 1'b1, {tile_id, `CRA_DST_TILE}, 24'h000203, 16'h0001, 8'h01, 32'h0);
        check(67'h0, 67'(got[32]));
        cmd(1'b0, 1'b0, {node_id, 8'h5a, `CRA_DST_PERI}, 24'h000203, 16'h0001, 8'h04, 32'h0);
        check(67'h0, 67'(got[32]));
        check(67'(c0), 67'(acc_cnt));
        $display("test reject done");
    endtask
    initial begin
        i_rst_n = 1'b0;
        {c_valid, c_w, c_p, c_dest, c_id, c_reg, c_n, c_data} = '0;
        acc_ok = 1'b0;
        acc_rdata = 32'h0;
        tile_id = 16'h0a0b;
        node_id = 16'h1c1d;
        repeat (16) @(negedge i_clk);
        i_rst_n = 1'b1;
        t_config();
        t_fail();
        t_periph();
        t_quiet();
        t_reject();
        print_verdict();
    end
endmodule
`default_nettype wire
